// File: design/seq_host_ctrl.sv
/*
 * Device end: paged block array, queue FIFOs, pause handshake, interrupt
 * status and gating, power-down. Assumes a host on the dev modport and a
 * sequencer on plain ports, all on mclk.
 */
// Functional notes
// - Array shown as 32-byte pages by pointer.
// - Auto-increment advances location on each access.
// - Driver clears auto-increment before random access.
// - Driver writes array only while paused.
// - Pause request answered by acknowledge at bit 2.
// - Driver command issue sequence through queue-in.
// - Sequencer pops queue-in, may push back.
// - Completion pushes queue-out, sets bit 1, runs.
// - Queue-out, count, status readable without pause.
// - Sequencer request self-pauses until host clears bit 0, then releases.
// - Masked SCSI event sets status and pauses.
// - Breakpoint match pauses, sets bit 3.
// - Breakpoint irq enabled by bit 3, cleared.
// - Failures set break status unless disabled.
// - Opcode parity error sets break and flag.
// - Software irq holds request while set.
// - Power-down freezes, suppresses irq until cleared.
// - Driver pauses sequencer before power-down.
`timescale 1ns/100ps
`default_nettype none
`include "seq_host_defines.svh"
module seq_host_ctrl #(
   parameter int PAGES  = `PAGE_COUNT,
   parameter int QDEPTH = `QUEUE_DEPTH
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               rst,
   // Host I/O port
   seq_io_if.dev                   io,
   // Sequencer queue access
   input  wire logic               seq_qin_pop,
   input  wire logic               seq_qin_push,
   input  wire seq_host_pkg::io_byte_t seq_qin_index,
   output logic                    qin_ready,
   output seq_host_pkg::io_byte_t  qin_head,
   // Sequencer events
   input  wire logic               seq_req,
   input  wire logic [3:0]         seq_code,
   input  wire logic               seq_done,
   input  wire seq_host_pkg::io_byte_t seq_done_index,
   input  wire logic [7:0]         scsi_cond_a,
   input  wire logic [7:0]         scsi_cond_b,
   input  wire logic [9:0]         seq_pc,
   input  wire logic               fail_opcode,
   input  wire logic               fail_seq_addr,
   input  wire logic               fail_host_addr,
   input  wire logic               parity_fault,
   // Sequencer run control
   output logic                    seq_run
);
   import seq_host_pkg::*;

   localparam int PW  = $clog2(PAGES);
   localparam int QAW = $clog2(QDEPTH);

   if (PAGES < 2 || (1 << PW) != PAGES || PAGES > 256) begin : g_bad_pages
      $error("PAGES must be a power of two from 2 to 256");
   end
   if (QDEPTH < 2 || (1 << QAW) != QDEPTH) begin : g_bad_depth
      $error("QDEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [PAGES*`PAGE_BYTES-1:0][7:0] arr;
      io_byte_t                 block_page_pointer;
      io_byte_t                 block_array_counter;
      logic                     global_irq_enable;
      logic                     pause_req;
      logic                     software_irq;
      logic                     power_down;
      logic                     pause_acknowledge;
      io_byte_t                 sequencer_control_reg;
      io_byte_t                 break_address_low;
      io_byte_t                 break_address_high;
      io_byte_t                 scsi_irq_mask_a;
      io_byte_t                 scsi_irq_mask_b;
      logic [3:0]               status;
      logic [3:0]               request_reason_code;
      logic [3:0]               error_flags;
      logic [QDEPTH-1:0][7:0]   qi_mem;
      logic [QAW-1:0]           qi_head;
      logic [QAW:0]             qi_cnt;
      logic [QDEPTH-1:0][7:0]   qo_mem;
      logic [QAW-1:0]           qo_head;
      logic [QAW:0]             qo_cnt;
      io_byte_t                 rdata;
      logic                     ack;
      logic                     irq;
      logic                     run;
      logic                     qready;
      io_byte_t                 qhead;
   } state_t;

   state_t s;
   state_t next_s;

   function automatic logic [QAW-1:0] slot(input logic [QAW-1:0] head,
                                           input logic [QAW:0]   cnt);
      slot = head + cnt[QAW-1:0];
   endfunction

   // --------------------
   // Next state
   // --------------------
   always_comb begin
      logic [PW+4:0] idx;
      logic          hit;
      logic          scsi_hit;
      logic          brk_hit;
      logic [3:0]    fails;
      next_s = s;
      idx = {s.block_page_pointer[PW-1:0], s.block_array_counter[4:0]};
      hit = 1'b0;
      scsi_hit = |(scsi_cond_a & s.scsi_irq_mask_a) | |(scsi_cond_b & s.scsi_irq_mask_b);
      brk_hit = s.run && !s.break_address_high[`BH_BREAK_DISABLE] &&
                seq_pc == {s.break_address_high[1:0], s.break_address_low};
      fails[`ER_PARITY] = parity_fault &&
                          !s.sequencer_control_reg[`SC_PARITY_DIS];
      fails[`ER_BAD_OPCODE]    = fail_opcode;
      fails[`ER_BAD_SEQ_ADDR]  = fail_seq_addr;
      fails[`ER_BAD_HOST_ADDR] = fail_host_addr;
      if (s.sequencer_control_reg[`SC_FAILURE_DIS])
         fails[3:1] = 3'b000;
      next_s.ack = io.io_rd | io.io_wr;

      // Host reads; only the array and queue-out have side effects.
      if (io.io_rd) begin
         unique case (io.io_addr)
            `IO_HOST_CONTROL: next_s.rdata = {1'b0, s.power_down, 1'b0,
                                 s.software_irq, 1'b0, s.pause_acknowledge,
                                 s.global_irq_enable, 1'b0};
            `IO_PAGE_POINTER:  next_s.rdata = s.block_page_pointer;
            `IO_ARRAY_COUNTER: next_s.rdata = s.block_array_counter;
            `IO_PAGE_VALUE: begin
               next_s.rdata = s.arr[idx];
               hit = 1'b1;
            end
            `IO_QUEUE_IN:      next_s.rdata = s.qi_mem[s.qi_head];
            `IO_QUEUE_OUT: begin
               next_s.rdata = (s.qo_cnt != '0) ? s.qo_mem[s.qo_head] : `RESET_BYTE;
               if (s.qo_cnt != '0) begin
                  next_s.qo_head = s.qo_head + 1'b1;
                  next_s.qo_cnt  = s.qo_cnt - 1'b1;
               end
            end
            `IO_QUEUE_OUT_CNT: next_s.rdata = 8'(s.qo_cnt);
            `IO_IRQ_STATUS:    next_s.rdata = {s.request_reason_code, s.status};
            `IO_SEQ_CONTROL:   next_s.rdata = s.sequencer_control_reg;
            `IO_BREAK_LOW:     next_s.rdata = s.break_address_low;
            `IO_BREAK_HIGH:    next_s.rdata = s.break_address_high;
            `IO_ERROR_FLAGS:   next_s.rdata = {4'h0, s.error_flags};
            `IO_SCSI_MASK_A:   next_s.rdata = s.scsi_irq_mask_a;
            `IO_SCSI_MASK_B:   next_s.rdata = s.scsi_irq_mask_b;
            default:           next_s.rdata = `RESET_BYTE;
         endcase
      end

      // Host writes. Clears come before the hardware sets below.
      if (io.io_wr) begin
         unique case (io.io_addr)
            `IO_HOST_CONTROL: begin
               next_s.global_irq_enable = io.io_wdata[`HC_GLOBAL_IRQ_EN];
               next_s.pause_req         = io.io_wdata[`HC_PAUSE] ||
                                          s.status[`ST_SEQ_REQUEST];
               next_s.software_irq      = io.io_wdata[`HC_SOFTWARE_IRQ];
               next_s.power_down        = io.io_wdata[`HC_POWER_DOWN];
            end
            `IO_PAGE_POINTER:  next_s.block_page_pointer = io.io_wdata;
            `IO_ARRAY_COUNTER: next_s.block_array_counter = io.io_wdata;
            `IO_PAGE_VALUE: begin
               next_s.arr[idx] = io.io_wdata;
               hit = 1'b1;
            end
            `IO_QUEUE_IN: begin
               if (s.qi_cnt != QDEPTH[QAW:0]) begin
                  next_s.qi_mem[slot(s.qi_head, s.qi_cnt)] = io.io_wdata;
                  next_s.qi_cnt = s.qi_cnt + 1'b1;
               end
            end
            `IO_IRQ_CLEAR: begin
               next_s.status = s.status & ~io.io_wdata[3:0];
               if (io.io_wdata[`ST_BREAK_FAIL])
                  next_s.error_flags = 4'h0;
            end
            `IO_SEQ_CONTROL: next_s.sequencer_control_reg = io.io_wdata;
            `IO_BREAK_LOW:   next_s.break_address_low = io.io_wdata;
            `IO_BREAK_HIGH:  next_s.break_address_high = io.io_wdata;
            `IO_SCSI_MASK_A: next_s.scsi_irq_mask_a = io.io_wdata;
            `IO_SCSI_MASK_B: next_s.scsi_irq_mask_b = io.io_wdata;
            default: ;
         endcase
      end

      // Auto-increment wraps within the selected page.
      if (hit && s.block_array_counter[`AC_AUTO_INC])
         next_s.block_array_counter[4:0] = s.block_array_counter[4:0] + 5'd1;

      // Sequencer side of queue-in: pop, and push back on a conflict.
      if (seq_qin_pop && s.qi_cnt != '0) begin
         next_s.qi_head = s.qi_head + 1'b1;
         next_s.qi_cnt  = next_s.qi_cnt - 1'b1;
      end
      if (seq_qin_push && next_s.qi_cnt != QDEPTH[QAW:0]) begin
         next_s.qi_mem[slot(next_s.qi_head, next_s.qi_cnt)] = seq_qin_index;
         next_s.qi_cnt = next_s.qi_cnt + 1'b1;
      end

      // Completion: no pause is taken for it.
      if (seq_done) begin
         if (next_s.qo_cnt != QDEPTH[QAW:0]) begin
            next_s.qo_mem[slot(next_s.qo_head, next_s.qo_cnt)] = seq_done_index;
            next_s.qo_cnt = next_s.qo_cnt + 1'b1;
         end
         next_s.status[`ST_COMMAND_DONE] = 1'b1;
      end

      if (seq_req) begin
         next_s.status[`ST_SEQ_REQUEST] = 1'b1;
         next_s.request_reason_code = seq_code;
         next_s.pause_req = 1'b1;
      end

      if (scsi_hit) begin
         next_s.status[`ST_SCSI_EVENT] = 1'b1;
         next_s.pause_req = 1'b1;
      end

      if (brk_hit || fails != 4'h0) begin
         next_s.status[`ST_BREAK_FAIL] = 1'b1;
         next_s.error_flags = next_s.error_flags | fails;
         next_s.pause_req = 1'b1;
      end

      // Acknowledge follows the registered pause, one cycle after the halt.
      next_s.pause_acknowledge = s.pause_req;
      next_s.run = !next_s.pause_req && !next_s.power_down;

      // Pending sources stay latched during power-down and show on release.
      next_s.irq = next_s.global_irq_enable && !next_s.power_down &&
                   (next_s.status[`ST_SEQ_REQUEST] || next_s.status[`ST_COMMAND_DONE] ||
                    next_s.status[`ST_SCSI_EVENT] ||
                    (next_s.status[`ST_BREAK_FAIL] &&
                     next_s.sequencer_control_reg[`SC_BREAK_IRQ_EN]) ||
                    next_s.software_irq);
      next_s.qready = next_s.qi_cnt != '0;
      next_s.qhead  = next_s.qi_mem[next_s.qi_head];
   end

   // --------------------
   // State register
   // --------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.break_address_high <= `RESET_BREAK_HIGH;
      end else begin
         s <= next_s;
      end
   end

   assign io.io_rdata = s.rdata;
   assign io.io_ack   = s.ack;
   assign io.irq      = s.irq;
   assign seq_run     = s.run;
   assign qin_ready   = s.qready;
   assign qin_head    = s.qhead;
endmodule
`default_nettype wire

// File: design/seq_host_defines.svh
/*
 * Offsets, field positions, reset values and sizes for the sequencer host
 * control block and its bridge. Assumes nothing; definitions only.
 */
`ifndef SEQ_HOST_DEFINES_SVH
`define SEQ_HOST_DEFINES_SVH

// --------------------
// Device I/O register offsets
// --------------------
`define IO_HOST_CONTROL   4'h0
`define IO_PAGE_POINTER   4'h1
`define IO_ARRAY_COUNTER  4'h2
`define IO_PAGE_VALUE     4'h3
`define IO_QUEUE_IN       4'h4
`define IO_QUEUE_OUT      4'h5
`define IO_QUEUE_OUT_CNT  4'h6
`define IO_IRQ_STATUS     4'h7
`define IO_IRQ_CLEAR      4'h8
`define IO_SEQ_CONTROL    4'h9
`define IO_BREAK_LOW      4'hA
`define IO_BREAK_HIGH     4'hB
`define IO_ERROR_FLAGS    4'hC
`define IO_SCSI_MASK_A    4'hD
`define IO_SCSI_MASK_B    4'hE

// --------------------
// Field positions
// --------------------
`define HC_GLOBAL_IRQ_EN  1
`define HC_PAUSE          2
`define HC_SOFTWARE_IRQ   4
`define HC_POWER_DOWN     6
`define ST_SEQ_REQUEST    0
`define ST_COMMAND_DONE   1
`define ST_SCSI_EVENT     2
`define ST_BREAK_FAIL     3
`define SC_BREAK_IRQ_EN   3
`define SC_PARITY_DIS     4
`define SC_FAILURE_DIS    5
`define BH_BREAK_DISABLE  7
`define AC_AUTO_INC       7
`define ER_PARITY         0
`define ER_BAD_OPCODE     1
`define ER_BAD_SEQ_ADDR   2
`define ER_BAD_HOST_ADDR  3

// --------------------
// Sizes and reset values
// --------------------
`define PAGE_BYTES        32
`define PAGE_COUNT        4
`define QUEUE_DEPTH       4
`define RESET_BYTE        8'h00
`define RESET_BREAK_HIGH  8'h80

// --------------------
// APB bridge register offsets
// --------------------
`define APB_COMMAND       12'h000
`define APB_STATUS        12'h004

`endif

// File: design/seq_host_pkg.sv
/*
 * Shared types for the sequencer host control block and its bridge.
 * Assumes the defines header is compiled alongside.
 */
package seq_host_pkg;
   typedef logic [7:0] io_byte_t;
   typedef logic [3:0] io_addr_t;
   typedef enum logic {
      BR_IDLE = 1'b0,
      BR_WAIT = 1'b1
   } bridge_state_t;
endpackage

// File: design/seq_io_if.sv
/*
 * Byte-wide I/O port between the host bridge and the device.
 * Assumes both ends share mclk.
 */
`timescale 1ns/100ps
`default_nettype none
interface seq_io_if;
   import seq_host_pkg::*;
   io_addr_t io_addr;
   logic     io_wr;
   logic     io_rd;
   io_byte_t io_wdata;
   io_byte_t io_rdata;
   logic     io_ack;
   logic     irq;

   modport dev (input io_addr, input io_wr, input io_rd, input io_wdata,
                output io_rdata, output io_ack, output irq);
   modport drv (output io_addr, output io_wr, output io_rd, output io_wdata,
                input io_rdata, input io_ack, input irq);
endinterface
`default_nettype wire

// File: design/seq_host_bridge.sv
/*
 * Host end: APB slave turning command writes into byte accesses on the
 * device port, reporting the result and the interrupt level.
 * Assumes driver software keeps the pause and queue discipline.
 */
`timescale 1ns/100ps
`default_nettype none
`include "seq_host_defines.svh"
module seq_host_bridge (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Device I/O port
   seq_io_if.drv            io,
   // Interrupt to the system
   output logic             irq_out
);
   import seq_host_pkg::*;

   typedef struct packed {
      bridge_state_t st;
      io_addr_t      addr;
      io_byte_t      wdata;
      logic          wr;
      logic          rd;
      io_byte_t      last;
      logic [31:0]   prdata;
      logic          pready;
      logic          irq;
   } state_t;

   state_t s;
   state_t next_s;

   // --------------------
   // Next state
   // --------------------
   always_comb begin
      next_s = s;
      next_s.wr = 1'b0;
      next_s.rd = 1'b0;
      next_s.pready = psel && !penable && !s.pready;
      if (psel && !penable)
         next_s.prdata = (paddr == `APB_STATUS) ?
                         {15'h0000, s.irq, s.last, 7'h00, s.st == BR_WAIT} : 32'h0000_0000;
      // One access in flight keeps driver steps in order.
      if (psel && penable && s.pready && pwrite && paddr == `APB_COMMAND &&
          s.st == BR_IDLE) begin
         next_s.addr  = pwdata[3:0];
         next_s.wdata = pwdata[15:8];
         next_s.rd    = pwdata[16];
         next_s.wr    = !pwdata[16];
         next_s.st    = BR_WAIT;
      end
      if (s.st == BR_WAIT && io.io_ack) begin
         next_s.last = io.io_rdata;
         next_s.st   = BR_IDLE;
      end
      next_s.irq = io.irq;
   end

   // --------------------
   // State register
   // --------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign io.io_addr  = s.addr;
   assign io.io_wdata = s.wdata;
   assign io.io_wr    = s.wr;
   assign io.io_rd    = s.rd;
   assign prdata      = s.prdata;
   assign pready      = s.pready;
   assign pslverr     = 1'b0;
   assign irq_out     = s.irq;
endmodule
`default_nettype wire

// File: tb/seq_host_ctrl_interrupts_assertions.sv
/*
 * Checker on the byte I/O port that joins the bridge and the device.
 * Assumes the bench wires it to the interface signals, all on mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "seq_host_defines.svh"
module seq_host_ctrl_interrupts_assertions #(
   parameter int QDEPTH = 4
) (
   // Clock and reset
   input wire logic                   mclk,
   input wire logic                   rst,
   // Byte port
   input wire seq_host_pkg::io_addr_t io_addr,
   input wire logic                   io_wr,
   input wire logic                   io_rd,
   input wire seq_host_pkg::io_byte_t io_wdata,
   input wire seq_host_pkg::io_byte_t io_rdata,
   input wire logic                   io_ack,
   input wire logic                   irq
);
   import seq_host_pkg::*;
   // --------------------
   // Port timing
   // --------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   logic hc_wr;
   assign hc_wr = io_wr && io_addr == `IO_HOST_CONTROL;

   a_ack_after_req: assert property ((io_rd || io_wr) |=> io_ack)
      else $error("access not acknowledged");
   a_ack_has_cause: assert property (io_ack |-> $past(io_rd || io_wr))
      else $error("acknowledge without access");
   a_rdata_held: assert property (!io_ack |-> $stable(io_rdata))
      else $error("read data moved between reads");
   a_single_access: assert property (!(io_rd && io_wr))
      else $error("read and write together");
   a_unmapped_zero: assert property ((io_rd && io_addr == 4'hF) |=> io_rdata == 8'h00)
      else $error("unmapped read not zero");
   // --------------------
   // Queue and interrupt line
   // --------------------
   a_count_bound: assert property ((io_rd && io_addr == `IO_QUEUE_OUT_CNT)
      |=> io_rdata <= QDEPTH)
      else $error("queue count above depth");
   a_gie_gate: assert property ((hc_wr && !io_wdata[1]) |-> ##2 !irq)
      else $error("request seen with enable off");
   a_pdown_quiet: assert property ((hc_wr && io_wdata[6]) |-> ##2 !irq)
      else $error("request seen in power down");
   a_software_irq_raise: assert property ((hc_wr && io_wdata[1] && io_wdata[4] && !io_wdata[6])
      |-> ##1 irq [*3])
      else $error("software request not held");
endmodule
`default_nettype wire

// File: tb/seq_host_ctrl_interrupts_test.sv
/*
 * Bench: APB master on the bridge, sequencer pins driven on the device,
 * queue and page models. Assumes both ends share mclk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "seq_host_defines.svh"
module seq_host_ctrl_interrupts_test;
   import seq_host_pkg::*;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irq_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        qpop, qpush, sreq, sdone, qin_ready, seq_run;
   io_byte_t    qidx, didx, qin_head, b, v, mem [0:127], qin [$], qout [$];
   logic [3:0]  scode, fl;
   logic [7:0]  sca, scb;
   logic [9:0]  pc;
   int          errors, compares, seed, cyc, i, k;

   seq_io_if seq_io_if_inst ();
   seq_host_ctrl #(.PAGES(4), .QDEPTH(4)) seq_host_ctrl_inst (.mclk(mclk), .rst(rst),
      .io(seq_io_if_inst.dev), .seq_qin_pop(qpop), .seq_qin_push(qpush),
      .seq_qin_index(qidx), .qin_ready(qin_ready), .qin_head(qin_head), .seq_req(sreq),
      .seq_code(scode), .seq_done(sdone), .seq_done_index(didx), .scsi_cond_a(sca),
      .scsi_cond_b(scb), .seq_pc(pc), .fail_opcode(fl[1]), .fail_seq_addr(fl[2]),
      .fail_host_addr(fl[3]), .parity_fault(fl[0]), .seq_run(seq_run));
   seq_host_bridge seq_host_bridge_inst (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .io(seq_io_if_inst.drv),
      .irq_out(irq_out));
   seq_host_ctrl_interrupts_assertions #(.QDEPTH(4)) seq_host_ctrl_interrupts_assertions_inst (
      .mclk(mclk), .rst(rst), .io_addr(seq_io_if_inst.io_addr),
      .io_wr(seq_io_if_inst.io_wr), .io_rd(seq_io_if_inst.io_rd),
      .io_wdata(seq_io_if_inst.io_wdata), .io_rdata(seq_io_if_inst.io_rdata),
      .io_ack(seq_io_if_inst.io_ack), .irq(seq_io_if_inst.irq));

   // --------------------
   // Clock, timeout and closing
   // --------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic test_done();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Roughly four times the run length, so a stuck handshake ends the run.
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 8000) begin
         errors = errors + 1;
         $display("mismatch at %0t: run timed out", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares = compares + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // --------------------
   // Bus tasks
   // --------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      chk(pslverr, 1'b0);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // One byte access on the device port; the read byte lands in b.
   task automatic io(input logic w, input io_addr_t a, input io_byte_t d);
      logic [31:0] r;
      apb(1'b1, `APB_COMMAND, {15'h0000, !w, d, 4'h0, a}, r);
      do apb(1'b0, `APB_STATUS, 32'h0000_0000, r); while (r[0] !== 1'b0);
      b = r[15:8];
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
   endtask

   // --------------------
   // Main sequence
   // --------------------
   initial begin
      seed = 81411;
      {errors, compares, cyc} = '0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {qpop, qpush, sreq, sdone, qidx, didx, scode, fl, sca, scb, pc} = '0;
      rst = 1'b1;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      io(1'b1, `IO_HOST_CONTROL, 8'h04);
      io(1'b0, `IO_HOST_CONTROL, 8'h00);
      chk(b[2], 1'b1);
      chk(seq_run, 1'b0);
      io(1'b0, 4'hF, 8'h00);
      chk(b, 8'h00);
      $display("pause test done");
      // Two full pages through auto-increment, so the counter wraps.
      for (k = 1; k < 4; k = k + 2) begin
         io(1'b1, `IO_PAGE_POINTER, 8'(k));
         io(1'b1, `IO_ARRAY_COUNTER, 8'h80);
         for (i = 0; i < 32; i++) begin
            mem[k * 32 + i] = 8'($random(seed));
            io(1'b1, `IO_PAGE_VALUE, mem[k * 32 + i]);
         end
      end
      for (k = 1; k < 4; k = k + 2) begin
         io(1'b1, `IO_PAGE_POINTER, 8'(k));
         io(1'b1, `IO_ARRAY_COUNTER, 8'h80);
         for (i = 0; i < 33; i++) begin
            io(1'b0, `IO_PAGE_VALUE, 8'h00);
            chk(b, mem[k * 32 + i % 32]);
         end
         io(1'b1, `IO_ARRAY_COUNTER, 8'h05);
         for (i = 0; i < 2; i++) begin
            io(1'b0, `IO_PAGE_VALUE, 8'h00);
            chk(b, mem[k * 32 + 5]);
         end
      end
      $display("array test done");
      // Queue-in filled past its depth; the fifth entry is dropped.
      for (i = 0; i < 5; i++) begin
         v = 8'($random(seed));
         if (i < 4)
            qin.push_back(v);
         io(1'b1, `IO_QUEUE_IN, v);
      end
      io(1'b0, `IO_QUEUE_IN, 8'h00);
      chk(b, qin[0]);
      io(1'b1, `IO_HOST_CONTROL, 8'h00);
      chk(seq_run, 1'b1);
      k = 0;
      while (qin.size() > 0) begin
         chk(qin_ready, 1'b1);
         chk(qin_head, qin[0]);
         v = qin.pop_front();
         qpop <= 1'b1;
         @(posedge mclk);
         qpop <= 1'b0;
         if (k == 0) begin
            qpush <= 1'b1;
            qidx  <= v;
            qin.push_back(v);
            @(posedge mclk);
            qpush <= 1'b0;
         end
         k = 1;
         settle();
      end
      chk(qin_ready, 1'b0);
      for (i = 0; i < 3; i++) begin
         v = 8'($random(seed));
         qout.push_back(v);
         sdone <= 1'b1;
         didx  <= v;
         @(posedge mclk);
         sdone <= 1'b0;
         @(posedge mclk);
      end
      settle();
      chk(seq_run, 1'b1);
      io(1'b0, `IO_QUEUE_OUT_CNT, 8'h00);
      chk(b, 8'd3);
      io(1'b0, `IO_IRQ_STATUS, 8'h00);
      chk(b, 8'h02);
      while (qout.size() > 0) begin
         io(1'b0, `IO_QUEUE_OUT, 8'h00);
         chk(b, qout.pop_front());
      end
      io(1'b0, `IO_QUEUE_OUT, 8'h00);
      chk(b, 8'h00);
      io(1'b1, `IO_IRQ_CLEAR, 8'h02);
      $display("queue test done");
      // Sequencer request pauses until cleared and released.
      v = 8'($random(seed));
      sreq  <= 1'b1;
      scode <= v[3:0];
      @(posedge mclk);
      sreq <= 1'b0;
      settle();
      chk(seq_run, 1'b0);
      io(1'b0, `IO_IRQ_STATUS, 8'h00);
      chk(b, {v[3:0], 4'h1});
      io(1'b1, `IO_HOST_CONTROL, 8'h00);
      chk(seq_run, 1'b0);
      io(1'b1, `IO_IRQ_CLEAR, 8'h01);
      io(1'b1, `IO_HOST_CONTROL, 8'h00);
      chk(seq_run, 1'b1);
      // An unmasked condition does nothing; a masked-in one pauses.
      io(1'b1, `IO_SCSI_MASK_B, 8'h10);
      io(1'b1, `IO_HOST_CONTROL, 8'h02);
      sca <= 8'h01;
      settle();
      chk({seq_run, irq_out}, 2'b10);
      scb <= 8'h10;
      settle();
      chk({seq_run, irq_out}, 2'b01);
      io(1'b0, `IO_IRQ_STATUS, 8'h00);
      chk(b[2], 1'b1);
      io(1'b1, `IO_HOST_CONTROL, 8'h04);
      chk(irq_out, 1'b0);
      scb <= 8'h00;
      io(1'b1, `IO_IRQ_CLEAR, 8'h04);
      io(1'b1, `IO_HOST_CONTROL, 8'h02);
      chk(seq_run, 1'b1);
      $display("request test done");
      // Breakpoint, first with its request enable off.
      io(1'b1, `IO_BREAK_LOW, 8'hA5);
      io(1'b1, `IO_BREAK_HIGH, 8'h02);
      pc <= 10'h2A5;
      settle();
      chk({seq_run, irq_out}, 2'b00);
      io(1'b0, `IO_IRQ_STATUS, 8'h00);
      chk(b[3], 1'b1);
      io(1'b1, `IO_SEQ_CONTROL, 8'h08);
      chk(irq_out, 1'b1);
      io(1'b1, `IO_IRQ_CLEAR, 8'h08);
      io(1'b0, `IO_IRQ_STATUS, 8'h00);
      chk({b[3], irq_out}, 2'b00);
      pc <= 10'h000;
      io(1'b1, `IO_BREAK_HIGH, 8'h80);
      io(1'b1, `IO_SEQ_CONTROL, 8'h00);
      io(1'b1, `IO_HOST_CONTROL, 8'h02);
      // Each failure source in turn, then with detection disabled.
      for (i = 0; i < 6; i++) begin
         if (i == 4)
            io(1'b1, `IO_SEQ_CONTROL, 8'h20);
         if (i == 5)
            io(1'b1, `IO_SEQ_CONTROL, 8'h30);
         fl <= (i < 4) ? 4'(1 << i) : 4'hF;
         @(posedge mclk);
         fl <= 4'h0;
         settle();
         io(1'b0, `IO_ERROR_FLAGS, 8'h00);
         chk(b, (i < 4) ? 8'(1 << i) : (i == 4) ? 8'h01 : 8'h00);
         chk(seq_run, i == 5);
         io(1'b1, `IO_IRQ_CLEAR, 8'h08);
         io(1'b1, `IO_HOST_CONTROL, 8'h02);
      end
      $display("break test done");
      // Software request and power down with an event pending.
      io(1'b1, `IO_HOST_CONTROL, 8'h12);
      chk(irq_out, 1'b1);
      io(1'b1, `IO_HOST_CONTROL, 8'h10);
      chk(irq_out, 1'b0);
      io(1'b1, `IO_HOST_CONTROL, 8'h46);
      sdone <= 1'b1;
      didx  <= 8'h00;
      @(posedge mclk);
      sdone <= 1'b0;
      settle();
      chk({seq_run, irq_out}, 2'b00);
      io(1'b1, `IO_HOST_CONTROL, 8'h02);
      chk(irq_out, 1'b1);
      $display("power test done");
      test_done();
   end
endmodule
`default_nettype wire
